// ===== adc_out_framer.sv
// per-channel serial framer with periodic check insertion and clock division
//
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
`include "adc_out_regs.svh"
module adc_out_framer
   import adc_out_pkg::*;
(
   input  wire logic         clk_sys_in,
   input  wire logic         resetn_in,
   input  wire logic [7:0]   addr_in,
   input  wire logic [7:0]   wdata_in,
   input  wire logic         wr_in,
   input  wire logic         rd_in,
   output logic      [7:0]   rdata_out,
   input  wire logic         sample_valid_in,
   output logic              sample_ready_out,
   input  wire logic [127:0] sample_data_in,
   input  wire logic         chip_error_in,
   input  wire logic         sync_in,
   output logic              data_out_clock_out,
   output logic      [7:0]   serial_data_lines_out,
   output logic              frame_busy_out
);
   logic [7:0]   cfg_ff;
   logic [7:0]   nxt_cfg;
   logic [7:0]   rdata_ff;
   logic [7:0]   nxt_rdata;
   crc_mode_t    crc_mode;
   frame_state_t state_ff;
   frame_state_t nxt_state;
   logic [4:0]   bit_idx_ff;
   logic [4:0]   nxt_bit_idx;
   logic [3:0]   smp_cnt_ff;
   logic [3:0]   nxt_smp_cnt;
   logic [3:0]   cnt_last;
   logic [1:0]   div_lat_ff;
   logic [1:0]   nxt_div_lat;
   logic         accept;
   logic         insert;
   logic         bit_tick;
   logic         data_out_clock_level;
   logic [7:0]   crc_acc_ff   [`NUM_CH];
   logic [7:0]   nxt_crc_acc  [`NUM_CH];
   logic [7:0]   crc_step     [`NUM_CH];
   logic [23:0]  shift_ff     [`NUM_CH];
   logic [23:0]  nxt_shift    [`NUM_CH];
   logic [23:0]  frame_word   [`NUM_CH];
   logic [8:0]   busy_cyc_ff;
   logic [8:0]   exp_cyc;

   // register port: one mapped config word, one status word
   always_comb begin
      nxt_cfg = cfg_ff;
      if (wr_in && addr_in == `OIC_ADDR) begin
         // upper nibble is reserved and stays zero
         nxt_cfg = {4'h0, wdata_in[`CRC_SEL_MSB:`DIV_LSB]};
      end
      nxt_rdata = 8'h00;
      if (rd_in && addr_in == `OIC_ADDR) begin
         nxt_rdata = cfg_ff;
      end else if (rd_in && addr_in == `STAT_ADDR) begin
         nxt_rdata = {3'h0, (state_ff == ST_SHIFT), smp_cnt_ff};
      end
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cfg_ff   <= `OIC_RESET;
         rdata_ff <= 8'h00;
      end else begin
         cfg_ff   <= nxt_cfg;
         rdata_ff <= nxt_rdata;
      end
   end

   assign rdata_out = rdata_ff;
   assign crc_mode  = crc_mode_t'(cfg_ff[`CRC_SEL_MSB:`CRC_SEL_LSB]);

   // sample counting decides which sample carries the check byte
   assign accept           = sample_valid_in && (state_ff == ST_IDLE);
   assign sample_ready_out = (state_ff == ST_IDLE);
   assign cnt_last = (crc_mode == CRC_EVERY4) ? `CNT_LAST_4 : `CNT_LAST_16;
   assign insert   = (crc_mode != CRC_NONE) && (smp_cnt_ff == cnt_last);

   always_comb begin
      nxt_smp_cnt = smp_cnt_ff;
      if (sync_in || crc_mode == CRC_NONE) begin
         nxt_smp_cnt = 4'h0;
      end else if (accept) begin
         nxt_smp_cnt = insert ? 4'h0 : smp_cnt_ff + 4'h1;
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < `NUM_CH; ch++) begin : g_chan
         crc8_unit u_crc (
            .crc_in  (crc_acc_ff[ch]),
            .data_in (sample_data_in[ch*`DATA_W +: `DATA_W]),
            .crc_out (crc_step[ch])
         );

         // status header: error flag on top, channel number in the low bits
         assign frame_word[ch] = {insert ? crc_step[ch]
                                         : {chip_error_in, 4'h0, 3'(ch)},
                                  sample_data_in[ch*`DATA_W +: `DATA_W]};

         always_comb begin
            nxt_crc_acc[ch] = crc_acc_ff[ch];
            if (sync_in || crc_mode == CRC_NONE) begin
               nxt_crc_acc[ch] = `CRC_SEED;
            end else if (accept) begin
               // restart after each inserted byte so it spans one period only
               nxt_crc_acc[ch] = insert ? `CRC_SEED : crc_step[ch];
            end
            nxt_shift[ch] = shift_ff[ch];
            if (accept) begin
               nxt_shift[ch] = frame_word[ch];
            end else if (bit_tick) begin
               nxt_shift[ch] = {shift_ff[ch][22:0], 1'b0};
            end
         end

         always_ff @(posedge clk_sys_in or negedge resetn_in) begin
            if (!resetn_in) begin
               crc_acc_ff[ch] <= `CRC_SEED;
               shift_ff[ch]   <= 24'h000000;
            end else begin
               crc_acc_ff[ch] <= nxt_crc_acc[ch];
               shift_ff[ch]   <= nxt_shift[ch];
            end
         end

         assign serial_data_lines_out[ch] = shift_ff[ch][`FRAME_W-1];
      end
   endgenerate

   // frame sequencing; divide code is frozen per frame to avoid a short pulse
   always_comb begin
      nxt_state   = state_ff;
      nxt_bit_idx = bit_idx_ff;
      nxt_div_lat = div_lat_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (accept) begin
               nxt_state   = ST_SHIFT;
               nxt_bit_idx = 5'h00;
               nxt_div_lat = cfg_ff[`DIV_MSB:`DIV_LSB];
            end
         end
         ST_SHIFT: begin
            if (bit_tick) begin
               if (bit_idx_ff == `FRAME_LAST) begin
                  nxt_state = ST_IDLE;
               end else begin
                  nxt_bit_idx = bit_idx_ff + 5'h01;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_ff   <= ST_IDLE;
         bit_idx_ff <= 5'h00;
         smp_cnt_ff <= 4'h0;
         div_lat_ff <= 2'b00;
      end else begin
         state_ff   <= nxt_state;
         bit_idx_ff <= nxt_bit_idx;
         smp_cnt_ff <= nxt_smp_cnt;
         div_lat_ff <= nxt_div_lat;
      end
   end

   clock_divider u_div (
      .clk_sys_in     (clk_sys_in),
      .resetn_in      (resetn_in),
      .run_in         (state_ff == ST_SHIFT),
      .div_code_in    (div_lat_ff),
      .bit_tick_out   (bit_tick),
      .data_out_clock_level_out (data_out_clock_level)
   );

   // undivided mode passes the master clock through a gate: no flop can
   // make a full-rate clock, and the enable switches on the rising edge while the clock is high
   assign data_out_clock_out = (div_lat_ff == 2'b11) ? (clk_sys_in && state_ff == ST_SHIFT)
                                                     : data_out_clock_level;
   assign frame_busy_out = (state_ff == ST_SHIFT);

   // helper for checking frame length against the divide code
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         busy_cyc_ff <= 9'h000;
      end else if (state_ff == ST_SHIFT) begin
         busy_cyc_ff <= busy_cyc_ff + 9'h001;
      end else begin
         busy_cyc_ff <= 9'h000;
      end
   end

   always_comb begin
      unique case (div_lat_ff)
         2'b00:   exp_cyc = `CYC_DIV8;
         2'b01:   exp_cyc = `CYC_DIV4;
         2'b10:   exp_cyc = `CYC_DIV2;
         2'b11:   exp_cyc = `CYC_DIV1;
      endcase
   end

   sequence s_accept_insert4;
      accept && crc_mode == CRC_EVERY4 && smp_cnt_ff == `CNT_LAST_4;
   endsequence

   a_frame_length: assert property (
      @(posedge clk_sys_in) disable iff (!resetn_in)
      $fell(state_ff == ST_SHIFT) |-> busy_cyc_ff == exp_cyc)
      else $error("frame length does not match divide code");

   a_insert_every4: assert property (
      @(posedge clk_sys_in) disable iff (!resetn_in)
      s_accept_insert4 |=> shift_ff[0][23:16] == $past(crc_step[0]) && smp_cnt_ff == 4'h0)
      else $error("check byte missing on fourth sample");

   a_no_crc_header: assert property (
      @(posedge clk_sys_in) disable iff (!resetn_in)
      (accept && crc_mode == CRC_NONE) |=> shift_ff[1][23:16] == {$past(chip_error_in), 7'h01})
      else $error("status header not sent with check disabled");

   a_wrap16: assert property (
      @(posedge clk_sys_in) disable iff (!resetn_in)
      (accept && !sync_in && cfg_ff[`CRC_SEL_MSB] && smp_cnt_ff == `CNT_LAST_16)
      |=> smp_cnt_ff == 4'h0 ##1 (smp_cnt_ff == 4'h0) [*1])
      else $error("sixteen-sample period wrong");

   a_count_advance: assert property (
      @(posedge clk_sys_in) disable iff (!resetn_in)
      (accept && !sync_in && crc_mode != CRC_NONE && !insert)
      |=> smp_cnt_ff == $past(smp_cnt_ff) + 4'h1)
      else $error("sample counter did not advance");

   a_sync_restart: assert property (
      @(posedge clk_sys_in) disable iff (!resetn_in)
      sync_in |=> smp_cnt_ff == 4'h0 && crc_acc_ff[3] == `CRC_SEED)
      else $error("sync did not restart check period");

   a_acc_data_only: assert property (
      @(posedge clk_sys_in) disable iff (!resetn_in)
      (accept && !sync_in && crc_mode != CRC_NONE && !insert)
      |=> crc_acc_ff[2] == $past(crc_step[2]))
      else $error("accumulator not fed by data");

   a_clock_idle_low: assert property (
      @(posedge clk_sys_in) disable iff (!resetn_in)
      (state_ff == ST_IDLE && div_lat_ff != 2'b11) |-> !data_out_clock_out)
      else $error("output clock runs outside a frame");

   a_cfg_readback: assert property (
      @(posedge clk_sys_in) disable iff (!resetn_in)
      (rd_in && addr_in == `OIC_ADDR) |=> rdata_out == $past(cfg_ff) && rdata_out[7:4] == 4'h0)
      else $error("config read back wrong");
endmodule : adc_out_framer

// ===== adc_out_framer_tb_top.sv
// self-checking bench: registers, clock division and check insertion
`timescale 1ns/100ps
`include "adc_out_regs.svh"
module adc_out_framer_tb_top;
   logic         clk_sys_in = 1'b0;
   logic         resetn_in = 1'b0;
   logic [7:0]   addr_in = 8'h00;
   logic [7:0]   wdata_in = 8'h00;
   logic         wr_in = 1'b0;
   logic         rd_in = 1'b0;
   logic [7:0]   rdata_out;
   logic         sample_valid_in = 1'b0;
   logic         sample_ready_out;
   logic [127:0] sample_data_in = '0;
   logic         chip_error_in = 1'b0;
   logic         sync_in = 1'b0;
   logic         data_out_clock_out;
   logic [7:0]   serial_data_lines_out;
   logic         frame_busy_out;
   logic [191:0] frame;
   int           bits;
   int           errors = 0;
   int           checks = 0;
   int           cyc = 0;
   logic [7:0]   acc [8];
   int           cnt;

   adc_out_framer u_adc_out_framer (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .sample_valid_in(sample_valid_in),
      .sample_ready_out(sample_ready_out), .sample_data_in(sample_data_in),
      .chip_error_in(chip_error_in), .sync_in(sync_in),
      .data_out_clock_out(data_out_clock_out),
      .serial_data_lines_out(serial_data_lines_out), .frame_busy_out(frame_busy_out));
   host_capture u_host_capture (.data_out_clock_in(data_out_clock_out), .busy_in(frame_busy_out),
      .lines_in(serial_data_lines_out), .frame_out(frame), .bits_out(bits));

   always #5 clk_sys_in = ~clk_sys_in;

   task end_sim;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_sim

   // whole run needs under two thousand cycles; this ceiling only catches a hang
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 30000) begin
         errors++;
         end_sim();
      end
   end

   task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask : chk

   task wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_sys_in);
      wr_in <= 1'b0;
   endtask : wr_reg

   task rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_sys_in);
      rd_in <= 1'b0;
      @(posedge clk_sys_in);
      chk(rdata_out, exp, "read data");
   endtask : rd_chk

   task pulse_sync;
      @(posedge clk_sys_in);
      sync_in <= 1'b1;
      @(posedge clk_sys_in);
      sync_in <= 1'b0;
      cnt = 0;
      for (int c = 0; c < 8; c++) acc[c] = 8'h00;
   endtask : pulse_sync

   function automatic logic [15:0] smp(input int k, input int c);
      return 16'((k + 1) * 40503) ^ 16'(c * 4369);
   endfunction : smp

   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [15:0] d);
      logic fb;
      for (int i = 15; i >= 0; i--) begin
         fb = c[7] ^ d[i];
         c = {c[6:0], 1'b0} ^ (fb ? 8'h07 : 8'h00);
      end
      return c;
   endfunction : crc8

   // hands one sample over and returns the number of busy cycles it took
   task send(input int k, input logic err, output int n);
      n = 0;
      @(posedge clk_sys_in);
      for (int c = 0; c < 8; c++) sample_data_in[16*c +: 16] <= smp(k, c);
      chip_error_in <= err;
      sample_valid_in <= 1'b1;
      do @(posedge clk_sys_in); while (sample_ready_out !== 1'b1);
      sample_valid_in <= 1'b0;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (frame_busy_out === 1'b1);
      n--;
      chk(serial_data_lines_out, 8'h00, "idle lines");
   endtask : send

   task expect_frame(input int k, input logic err, input logic [1:0] m);
      logic       last;
      logic [7:0] hdr;
      logic [15:0] d;
      last = (m == 2'b01 && cnt == 3) || (m[1] && cnt == 15);
      chk(bits, 24, "bit count");
      for (int c = 0; c < 8; c++) begin
         d = smp(k, c);
         if (m != 2'b00) acc[c] = crc8(acc[c], d);
         hdr = last ? acc[c] : {err, 4'h0, 3'(c)};
         chk(frame[24*c +: 24], {hdr, d}, "frame word");
         if (last) acc[c] = 8'h00;
      end
      cnt = (m == 2'b00 || last) ? 0 : cnt + 1;
   endtask : expect_frame

   task t_regs;
      rd_chk(`OIC_ADDR, 8'h00);
      wr_reg(`OIC_ADDR, 8'hFF);
      rd_chk(`OIC_ADDR, 8'h0F);
      wr_reg(8'h33, 8'h55);
      rd_chk(8'h33, 8'h00);
      @(posedge clk_sys_in);
      resetn_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      resetn_in <= 1'b1;
      rd_chk(`OIC_ADDR, 8'h00);
      $display("test regs done");
   endtask : t_regs

   // slower codes are what a host picks when time allows
   task t_div;
      int n;
      for (int code = 0; code < 4; code++) begin
         wr_reg(`OIC_ADDR, 8'(code));
         pulse_sync();
         send(code, code[0], n);
         chk(n, 24 * (8 >> code), "frame length");
         expect_frame(code, code[0], 2'b00);
      end
      $display("test div done");
   endtask : t_div

   // undivided clock, as a host needs for dense output
   task t_crc(input logic [1:0] m, input int ns, input int sync_at);
      int n;
      wr_reg(`OIC_ADDR, {4'h0, m, 2'b11});
      pulse_sync();
      for (int k = 0; k < ns; k++) begin
         if (k == sync_at) pulse_sync();
         send(k, k[0], n);
         expect_frame(k, k[0], m);
      end
      // status word: idle, and the sample count the host model expects
      rd_chk(`STAT_ADDR, 8'(cnt));
      $display("test crc mode %0d done", m);
   endtask : t_crc

   initial begin
      repeat (2) @(posedge clk_sys_in);
      resetn_in <= 1'b1;
      t_regs();
      t_div();
      t_crc(2'b00, 5, -1);
      t_crc(2'b01, 10, 6);
      t_crc(2'b10, 17, -1);
      t_crc(2'b11, 16, -1);
      end_sim();
   end
endmodule : adc_out_framer_tb_top

// ===== adc_out_pkg.sv
// types shared by the output framer and its clock divider
package adc_out_pkg;
   typedef enum logic [1:0] {
      CRC_NONE    = 2'b00,
      CRC_EVERY4  = 2'b01,
      CRC_EVERY16 = 2'b10,
      CRC_EVERY16B = 2'b11
   } crc_mode_t;

   typedef enum logic [1:0] {
      DIV_BY8 = 2'b00,
      DIV_BY4 = 2'b01,
      DIV_BY2 = 2'b10,
      DIV_BY1 = 2'b11
   } div_mode_t;

   typedef enum logic {
      ST_IDLE  = 1'b0,
      ST_SHIFT = 1'b1
   } frame_state_t;
endpackage : adc_out_pkg

// ===== adc_out_regs.svh
// register map, field positions and timing counts of the output framer
`ifndef ADC_OUT_REGS_SVH
`define ADC_OUT_REGS_SVH

`define OIC_ADDR       8'h07
`define OIC_RESET      8'h00
`define STAT_ADDR      8'h0A
`define CRC_SEL_MSB    3
`define CRC_SEL_LSB    2
`define DIV_MSB        1
`define DIV_LSB        0
`define CRC_POLY       8'h07
`define CRC_SEED       8'h00
`define CNT_LAST_4     4'h3
`define CNT_LAST_16    4'hF
`define NUM_CH         8
`define DATA_W         16
`define FRAME_W        24
`define FRAME_LAST     5'h17
`define HDR_ERR_BIT    7
`define CYC_DIV8       9'h0C0
`define CYC_DIV4       9'h060
`define CYC_DIV2       9'h030
`define CYC_DIV1       9'h018
`define PH_LAST_DIV8   3'h7
`define PH_LAST_DIV4   3'h3
`define PH_LAST_DIV2   3'h1
`define PH_HALF_DIV8   3'h4
`define PH_HALF_DIV4   3'h2
`define PH_HALF_DIV2   3'h1

`endif

// ===== clock_divider.sv
// divides the master clock into bit periods and the output clock level
`timescale 1ns/100ps
`include "adc_out_regs.svh"
module clock_divider
   import adc_out_pkg::*;
(
   input  wire logic       clk_sys_in,
   input  wire logic       resetn_in,
   input  wire logic       run_in,
   input  wire logic [1:0] div_code_in,
   output logic            bit_tick_out,
   output logic            data_out_clock_level_out
);
   logic [2:0] phase_ff;
   logic [2:0] nxt_phase;
   logic [2:0] ph_last;
   logic [2:0] ph_half;

   always_comb begin
      unique case (div_mode_t'(div_code_in))
         DIV_BY8: begin
            ph_last = `PH_LAST_DIV8;
            ph_half = `PH_HALF_DIV8;
         end
         DIV_BY4: begin
            ph_last = `PH_LAST_DIV4;
            ph_half = `PH_HALF_DIV4;
         end
         DIV_BY2: begin
            ph_last = `PH_LAST_DIV2;
            ph_half = `PH_HALF_DIV2;
         end
         DIV_BY1: begin
            ph_last = 3'h0;
            ph_half = 3'h0;
         end
      endcase
      bit_tick_out = run_in && (phase_ff == ph_last);
      // in the divided modes, high in the first half of each bit so the host samples on the fall
      data_out_clock_level_out = run_in && (phase_ff < ph_half);
      if (!run_in || bit_tick_out) begin
         nxt_phase = 3'h0;
      end else begin
         nxt_phase = phase_ff + 3'h1;
      end
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         phase_ff <= 3'h0;
      end else begin
         phase_ff <= nxt_phase;
      end
   end

   sequence s_div8_gap;
      !bit_tick_out [*7] ##1 bit_tick_out;
   endsequence

   // only gaps inside one frame are checked; the last tick drops run
   a_div8_tick_gap: assert property (
      @(posedge clk_sys_in) disable iff (!resetn_in)
      (bit_tick_out && run_in && div_code_in == 2'b00) ##1 run_in |-> s_div8_gap)
      else $error("divide by eight bit period wrong");

   a_div1_every_cycle: assert property (
      @(posedge clk_sys_in) disable iff (!resetn_in)
      (run_in && div_code_in == 2'b11) |-> bit_tick_out)
      else $error("undivided clock must shift every cycle");
endmodule : clock_divider

// ===== crc8_unit.sv
// one 16-bit step of the 8-bit check, msb first
`timescale 1ns/100ps
`include "adc_out_regs.svh"
module crc8_unit
   import adc_out_pkg::*;
(
   input  wire logic [7:0]  crc_in,
   input  wire logic [15:0] data_in,
   output logic      [7:0]  crc_out
);
   logic [7:0] c;
   logic       fb;

   always_comb begin
      c  = crc_in;
      fb = 1'b0;
      for (int i = `DATA_W - 1; i >= 0; i--) begin
         fb = c[7] ^ data_in[i];
         c  = {c[6:0], 1'b0} ^ (fb ? `CRC_POLY : 8'h00);
      end
      crc_out = c;
   end
endmodule : crc8_unit

// ===== host_capture.sv
// host side capture of the eight serial lines, one 24-bit word per line
`timescale 1ns/100ps
module host_capture (
   input  wire logic         data_out_clock_in,
   input  wire logic         busy_in,
   input  wire logic [7:0]   lines_in,
   output logic      [191:0] frame_out,
   output int                bits_out
);
   initial begin
      frame_out = '0;
      bits_out = 0;
   end
   // busy stands in for the data-ready strobe that frames each transfer
   always @(posedge busy_in) bits_out = 0;
   // sample mid-bit on the falling edge; a gated clock may glitch at frame end, so cap at 24
   always @(negedge data_out_clock_in) begin
      if (busy_in === 1'b1 && bits_out < 24) begin
         for (int n = 0; n < 8; n++) frame_out[24*n +: 24] = {frame_out[24*n +: 23], lines_in[n]};
         bits_out = bits_out + 1;
      end
   end
endmodule : host_capture
